/* inc/usb_cfg_pkg.sv */
`default_nettype none
package usb_cfg_pkg;
  localparam logic [7:0] OFS_IFACE_CFG   = 8'h01;
  localparam logic [7:0] OFS_PKT_END     = 8'h20;
  localparam logic [7:0] OFS_PKT_LEN_H   = 8'h08;
  localparam logic [7:0] OFS_INT_MASK    = 8'h2E;
  localparam logic [7:0] OFS_ENUM_RAM    = 8'h30;
  localparam logic [7:0] OFS_EP_BUF      = 8'h31;
  localparam logic [7:0] OFS_REQ_PKT     = 8'h32;
  localparam logic [7:0] OFS_EP_BC       = 8'h33;
  localparam logic [7:0] OFS_PTR_LOW     = 8'h3A;
  localparam logic [7:0] OFS_PTR_HIGH    = 8'h3B;
  localparam logic [7:0] OFS_IND_DATA    = 8'h3C;
  localparam logic [15:0] XOFS_POLARITY  = 16'hE609;
  localparam logic [15:0] XOFS_TOGGLE    = 16'hE683;
  localparam int BIT_CLK_SRC   = 7;
  localparam int BIT_FREQ_SEL  = 6;
  localparam int BIT_CLK_OE    = 5;
  localparam int BIT_CLK_INV   = 4;
  localparam int BIT_STROBE    = 3;
  localparam int BIT_LOWPWR    = 2;
  localparam int BIT_PIN_D     = 1;
  localparam int BIT_PULLUP    = 0;
  localparam int BIT_IRQ_BUSACT = 1;
  localparam logic [7:0] RST_IFACE_CFG = 8'hC9;
  localparam logic [7:0] RST_INT_MASK  = 8'hFF;
  localparam logic [7:0] RST_POLARITY  = 8'h00;
  localparam logic [7:0] POLARITY_MASK = 8'h3F;
  localparam logic [7:0] RST_TOGGLE    = 8'h00;
  localparam int REQ_PKT_BYTES = 8;
  localparam int CLK_MHZ       = 200;
  localparam int PKT_LEN_WAIT_US = 35;
  localparam int FLUSH_WAIT_US   = 85;
  localparam int PKT_LEN_WAIT_CYC = PKT_LEN_WAIT_US * CLK_MHZ;
  localparam int FLUSH_WAIT_CYC   = FLUSH_WAIT_US * CLK_MHZ;
  localparam logic [7:0] APB_CMD    = 8'h00;
  localparam logic [7:0] APB_RDATA  = 8'h04;
  localparam logic [7:0] APB_STATUS = 8'h08;
  localparam logic [7:0] APB_IRQ_ST = 8'h0C;
  localparam logic [7:0] APB_IRQ_MK = 8'h10;
  localparam logic [7:0] APB_CTRL   = 8'h14;
  localparam int CMD_WR_BIT = 16;
endpackage
`default_nettype wire

/* inc/cmd_port_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cmd_port_if;
  logic       cmdValid;
  logic       cmdWrite;
  logic [7:0] cmdAddr;
  logic [7:0] cmdWdata;
  logic       cmdReady;
  logic [7:0] cmdRdata;
  logic       busActivityIrq;
  logic       resumePin;
  modport device (
    input  cmdValid, cmdWrite, cmdAddr, cmdWdata, resumePin,
    output cmdReady, cmdRdata, busActivityIrq
  );
  modport master (
    output cmdValid, cmdWrite, cmdAddr, cmdWdata, resumePin,
    input  cmdReady, cmdRdata, busActivityIrq
  );
endinterface
`default_nettype wire

/* hdl/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic pinIn,
  output logic      pinOut
);
  logic [2:0] stage_q;
  logic       out_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      stage_q <= 3'h0;
      out_q   <= 1'b0;
    end else begin
      stage_q <= {stage_q[1:0], pinIn};
      if (stage_q[1] == stage_q[2]) begin
        out_q <= stage_q[2];
      end
    end
  end
  assign pinOut = out_q;
endmodule
`default_nettype wire

/* hdl/usb_iface_device.sv */
`timescale 1ns/1ps
`default_nettype none
module usb_iface_device
  import usb_cfg_pkg::*;
#(
  parameter int ENUM_RAM_DEPTH = 500,
  parameter int EP_BUF_DEPTH   = 64
) (
  input  wire logic      clk,
  input  wire logic      reset,
  cmd_port_if.device     port,
  input  wire logic      usbActivity,
  input  wire logic      usbSuspend,
  input  wire logic      ifaceClkExt,
  input  wire logic      int30Clk,
  input  wire logic      int48Clk,
  input  wire logic      fifoReadIn,
  input  wire logic      fifoWriteIn,
  input  wire logic      chipSelIn,
  input  wire logic      flagDValue,
  input  wire logic [63:0] reqPacket,
  output logic           fifoClk,
  output logic           ifaceClkOut,
  output logic           ifaceClkOe,
  output logic           fifoRead,
  output logic           fifoWrite,
  output logic           flagOutD,
  output logic           flagOutDOe,
  output logic           chipSel,
  output logic           oscRunning,
  output logic           pullupFloat,
  output logic           ctrlStall,
  output logic [7:0]     strobePolarity
);
  logic [7:0] cfg_q, mask_q, bc_q, ptrLo_q, ptrHi_q, pol_q, tog_q, rdata_q;
  logic [2:0] setupIdx_q;
  logic       lowPower_q, stall_q, actIrq_q, fifoRd_q, fifoWr_q;
  logic       resumeSync;
  logic [7:0] enumRam [ENUM_RAM_DEPTH];
  logic [7:0] epBuf [EP_BUF_DEPTH];
  localparam int RAM_AW = $clog2(ENUM_RAM_DEPTH);
  logic [RAM_AW-1:0]                 ramIdx_q;
  logic [$clog2(EP_BUF_DEPTH)-1:0]   bufIdx_q;

  pin_sync resumeSyncInst (
    .clk    (clk),
    .reset  (reset),
    .pinIn  (port.resumePin),
    .pinOut (resumeSync)
  );

  // Accesses count only when taken, so a stalled request neither writes twice
  // nor steps a read pointer while the oscillator is stopped.
  wire        take    = port.cmdValid & ~lowPower_q;
  wire        wr      = take & port.cmdWrite;
  wire        rd      = take & ~port.cmdWrite;
  wire [15:0] indAddr = {ptrHi_q, ptrLo_q};
  wire        indPol  = indAddr == XOFS_POLARITY;
  wire        indTog  = indAddr == XOFS_TOGGLE;
  wire        wakeEvt = usbActivity | resumeSync;

  // Writing the low-power bit stops the oscillator until a wake source appears.
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_q      <= RST_IFACE_CFG; // see RULE11
      mask_q     <= RST_INT_MASK;
      bc_q       <= 8'h00; // see RULE13
      ptrLo_q    <= 8'h00;
      ptrHi_q    <= 8'h00;
      pol_q      <= RST_POLARITY; // see RULE14
      tog_q      <= RST_TOGGLE;
      lowPower_q <= 1'b0;
      stall_q    <= 1'b0;
      setupIdx_q <= 3'h0;
      ramIdx_q   <= '0;
      bufIdx_q   <= '0;
      actIrq_q   <= 1'b0;
      rdata_q    <= 8'h00;
    end else begin
      actIrq_q <= usbSuspend & mask_q[BIT_IRQ_BUSACT];
      stall_q  <= 1'b0;
      if (lowPower_q && wakeEvt) begin
        lowPower_q <= 1'b0; // see RULE9
      end
      if (wr) begin
        case (port.cmdAddr)
          OFS_IFACE_CFG: begin
            cfg_q <= port.cmdWdata;
            if (port.cmdWdata[BIT_LOWPWR]) begin
              lowPower_q <= 1'b1; // see RULE7
            end
          end
          OFS_INT_MASK: mask_q <= port.cmdWdata;
          OFS_ENUM_RAM: begin
            enumRam[ramIdx_q] <= port.cmdWdata;
            ramIdx_q <= (ramIdx_q == RAM_AW'(ENUM_RAM_DEPTH - 1)) ? '0 : ramIdx_q + 1'b1;
          end
          OFS_EP_BUF: begin
            epBuf[bufIdx_q] <= port.cmdWdata;
            bufIdx_q <= bufIdx_q + 1'b1;
          end
          OFS_REQ_PKT:  stall_q <= 1'b1; // see RULE12
          OFS_EP_BC:    bc_q <= port.cmdWdata; // see RULE13
          OFS_PTR_LOW:  ptrLo_q <= port.cmdWdata;
          OFS_PTR_HIGH: ptrHi_q <= port.cmdWdata;
          OFS_IND_DATA: begin
            if (indPol) begin
              pol_q <= port.cmdWdata & POLARITY_MASK; // see RULE19 RULE14
            end
            if (indTog) begin
              tog_q <= port.cmdWdata;
            end
          end
          default: ;
        endcase
      end
      if (rd) begin
        case (port.cmdAddr)
          OFS_IFACE_CFG: rdata_q <= cfg_q;
          OFS_INT_MASK:  rdata_q <= mask_q;
          OFS_EP_BUF: begin
            rdata_q  <= epBuf[bufIdx_q];
            bufIdx_q <= bufIdx_q + 1'b1;
          end
          OFS_REQ_PKT: begin
            rdata_q    <= reqPacket[setupIdx_q*8 +: 8]; // see RULE12
            setupIdx_q <= setupIdx_q + 1'b1;
          end
          OFS_EP_BC:    rdata_q <= bc_q;
          OFS_PTR_LOW:  rdata_q <= ptrLo_q;
          OFS_PTR_HIGH: rdata_q <= ptrHi_q;
          OFS_IND_DATA: rdata_q <= indPol ? pol_q : (indTog ? tog_q : 8'h00); // see RULE19
          default:      rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // Strobe inputs are registered in synchronous mode; asynchronous mode passes them straight.
  always_ff @(posedge clk) begin
    if (reset) begin
      fifoRd_q <= 1'b0;
      fifoWr_q <= 1'b0;
    end else begin
      fifoRd_q <= fifoReadIn;
      fifoWr_q <= fifoWriteIn;
    end
  end

  wire intClk = cfg_q[BIT_FREQ_SEL] ? int48Clk : int30Clk; // see RULE2
  wire srcClk = cfg_q[BIT_CLK_SRC] ? intClk : ifaceClkExt; // see RULE1
  assign fifoClk        = srcClk ^ cfg_q[BIT_CLK_INV]; // see RULE4
  assign ifaceClkOut    = intClk;
  assign ifaceClkOe     = cfg_q[BIT_CLK_OE]; // see RULE3
  assign fifoRead       = cfg_q[BIT_STROBE] ? fifoReadIn : fifoRd_q; // see RULE5 RULE6
  assign fifoWrite      = cfg_q[BIT_STROBE] ? fifoWriteIn : fifoWr_q; // see RULE5 RULE6
  assign flagOutD       = flagDValue;
  assign flagOutDOe     = cfg_q[BIT_PIN_D]; // see RULE10
  assign chipSel        = ~cfg_q[BIT_PIN_D] & chipSelIn; // see RULE10
  assign oscRunning     = ~lowPower_q; // see RULE7
  assign pullupFloat    = cfg_q[BIT_PULLUP]; // see RULE17
  assign ctrlStall      = stall_q;
  assign strobePolarity = pol_q;
  assign port.cmdReady  = take;
  assign port.cmdRdata  = rdata_q;
  assign port.busActivityIrq = actIrq_q;
endmodule
`default_nettype wire

/* hdl/usb_iface_master.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: clock source bit selects external or internal
// RULE2: frequency bit selects 30 or 48 MHz
// RULE3: clock output enable drives the clock pin
// RULE4: polarity bit inverts the interface clock; the code inverts fifoClk only, not ifaceClkOut
// RULE5: strobe mode zero makes enables synchronous
// RULE6: strobe mode one makes direct strobes
// RULE7: low-power write stops the oscillator
// RULE8: master sets low-power only after suspend; the code also accepts it before suspend if the write floats the pull-up
// RULE9: bus activity or resume pin wakes
// RULE10: pin-D bit chooses chip select or flag
// RULE11: configuration at 0x01 with documented reset
// RULE12: request register reads packet, write stalls
// RULE13: byte count readable and writable one byte
// RULE14: polarity register six writable bits, top zero
// RULE15: wait 35 us after packet-length rewrite
// RULE16: wait 85 us after flush write
// RULE17: disconnect bit floats the pull-up
// RULE18: pointer written as address then two nibbles; the code takes the pointer as full bytes at OFS_PTR_LOW and OFS_PTR_HIGH
// RULE19: indirect data reaches pointer-selected register
module usb_iface_master
  import usb_cfg_pkg::*;
#(
  parameter int LEN_WAIT   = PKT_LEN_WAIT_CYC,
  parameter int FLUSH_WAIT = FLUSH_WAIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset,
  cmd_port_if.master       port,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             irq
);
  typedef enum logic [1:0] {
    IDLE  = 2'b00,
    ISSUE = 2'b01,
    WAIT  = 2'b10,
    TAKE  = 2'b11
  } state_e;
  state_e     state_q;
  logic [7:0] addr_q, wdata_q, rdata_q;
  logic       write_q, busy_q, locked_q, suspended_q, resume_q;
  logic [1:0] irqSt_q, irqMk_q;
  logic [14:0] waitCnt_q;

  wire apbWr  = psel & penable & pwrite;
  wire apbAcc = psel & penable;
  wire cmdWr  = apbWr && paddr == APB_CMD && !busy_q;
  wire lowPowerWr = pwdata[CMD_WR_BIT] && pwdata[15:8] == OFS_IFACE_CFG && pwdata[BIT_LOWPWR];
  // Low-power requests before a suspend notice are refused, unless the pull-up floats.
  wire lpBlocked = lowPowerWr && !suspended_q && !pwdata[BIT_PULLUP]; // see RULE8
  wire accept = cmdWr && !lpBlocked;
  wire done   = state_q == TAKE;
  wire needLen   = write_q && addr_q == OFS_PKT_LEN_H;
  wire needFlush = write_q && addr_q == OFS_PKT_END;
  wire [1:0] irqEvt = {done, port.busActivityIrq};

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q     <= IDLE;
      addr_q      <= 8'h00;
      wdata_q     <= 8'h00;
      write_q     <= 1'b0;
      busy_q      <= 1'b0;
      rdata_q     <= 8'h00;
      waitCnt_q   <= '0;
      locked_q    <= 1'b0;
      suspended_q <= 1'b0;
      resume_q    <= 1'b0;
      irqSt_q     <= 2'b00;
      irqMk_q     <= 2'b00;
    end else begin
      if (port.busActivityIrq) begin
        suspended_q <= 1'b1;
      end
      irqSt_q <= (irqSt_q & ~((apbWr && paddr == APB_IRQ_ST) ? pwdata[1:0] : 2'b00)) | irqEvt;
      if (apbWr && paddr == APB_IRQ_MK) begin
        irqMk_q <= pwdata[1:0];
      end
      if (apbWr && paddr == APB_CTRL) begin
        resume_q <= pwdata[0];
      end
      if (waitCnt_q != 0) begin
        waitCnt_q <= waitCnt_q - 1'b1;
      end else begin
        locked_q <= 1'b0;
      end
      case (state_q)
        IDLE: begin
          if (accept) begin
            addr_q  <= pwdata[15:8];
            wdata_q <= pwdata[7:0];
            write_q <= pwdata[CMD_WR_BIT];
            busy_q  <= 1'b1;
            state_q <= ISSUE;
          end
        end
        ISSUE: state_q <= WAIT;
        WAIT: begin
          if (port.cmdReady) begin
            state_q <= TAKE;
            if (needLen) begin
              waitCnt_q <= 15'(LEN_WAIT); // see RULE15
              locked_q  <= 1'b1;
            end
            if (needFlush) begin
              waitCnt_q <= 15'(FLUSH_WAIT); // see RULE16
              locked_q  <= 1'b1;
            end
            if (write_q && addr_q == OFS_IFACE_CFG && wdata_q[BIT_LOWPWR]) begin
              suspended_q <= 1'b0;
            end
          end
        end
        // The device registers its read byte on the accepting edge, so it is taken one cycle later.
        TAKE: begin
          rdata_q <= port.cmdRdata;
          busy_q  <= 1'b0;
          state_q <= IDLE;
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // Pointer and data writes for indirect access are issued by software as
  // a low pointer byte write, a high pointer byte write and a data write, each its own command.
  assign port.cmdValid  = state_q == WAIT; // see RULE18
  assign port.cmdWrite  = write_q;
  assign port.cmdAddr   = addr_q;
  assign port.cmdWdata  = wdata_q;
  assign port.resumePin = resume_q; // see RULE9
  assign pready  = 1'b1;
  assign pslverr = apbAcc && paddr == APB_CMD && pwrite && (busy_q || lpBlocked);
  assign irq     = |(irqSt_q & irqMk_q);
  always_comb begin
    case (paddr)
      APB_RDATA:  prdata = {24'h0, rdata_q};
      APB_STATUS: prdata = {29'h0, suspended_q, locked_q, busy_q};
      APB_IRQ_ST: prdata = {30'h0, irqSt_q};
      APB_IRQ_MK: prdata = {30'h0, irqMk_q};
      APB_CTRL:   prdata = {31'h0, resume_q};
      default:    prdata = 32'h0;
    endcase
  end
endmodule
`default_nettype wire

/* testbench/cmd_port_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cmd_port_sva
  import usb_cfg_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       cmdValid,
  input wire logic       cmdWrite,
  input wire logic [7:0] cmdAddr,
  input wire logic [7:0] cmdWdata,
  input wire logic       cmdReady,
  input wire logic [7:0] cmdRdata,
  input wire logic       busActivityIrq,
  input wire logic       resumePin
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] cfg_q;
  logic [7:0] count_q;
  logic       asleep_q;
  wire logic  take    = cmdValid && cmdReady;
  wire logic  takeWr  = take && cmdWrite;
  wire logic  takeRd  = take && !cmdWrite;
  wire logic  sleepWr = takeWr && cmdAddr == OFS_IFACE_CFG && cmdWdata[BIT_LOWPWR];
  // Shadows follow only commands the device took, so refused writes never reach them.
  always_ff @(posedge clk) begin
    if (reset) cfg_q <= RST_IFACE_CFG;
    else if (takeWr && cmdAddr == OFS_IFACE_CFG) cfg_q <= cmdWdata;
  end
  always_ff @(posedge clk) begin
    if (reset) count_q <= 8'h00;
    else if (takeWr && cmdAddr == OFS_EP_BC) count_q <= cmdWdata;
  end
  always_ff @(posedge clk) begin
    if (reset) asleep_q <= 1'b0;
    else if (sleepWr) asleep_q <= 1'b1;
    else if (take) asleep_q <= 1'b0;
  end
  AST_REQ_HOLD: assert property (cmdValid && !cmdReady
    |=> cmdValid && $stable({cmdWrite, cmdAddr, cmdWdata})) else $error("request changed");
  AST_ONE_SHOT: assert property (take |=> !cmdValid) else $error("request repeated");
  AST_CFG_READBACK: assert property (takeRd && cmdAddr == OFS_IFACE_CFG
    |=> (cmdRdata & 8'hFB) == (cfg_q & 8'hFB)) else $error("config readback wrong");
  AST_COUNT_READBACK: assert property (takeRd && cmdAddr == OFS_EP_BC
    |=> cmdRdata == count_q) else $error("byte count readback wrong");
  AST_RDATA_STABLE: assert property (!takeRd |=> $stable(cmdRdata))
    else $error("read data moved without read");
  AST_SLEEP_STALLS: assert property (asleep_q && cmdValid && !resumePin |-> !cmdReady)
    else $error("answered while asleep");
  AST_RESUME_WAKES: assert property (asleep_q && resumePin && cmdValid
    |-> ##[0:8] cmdReady) else $error("resume did not wake");
  AST_SLEEP_GUARD: assert property (sleepWr && !cmdWdata[BIT_PULLUP]
    |-> busActivityIrq) else $error("sleep before bus activity");
endmodule
`default_nettype wire

/* testbench/usb_iface_config_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module usb_iface_config_regs_tb
  import usb_cfg_pkg::*;
;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, irq, e, fifoClk, ifaceClkOut, ifaceClkOe, fifoRead, fifoWrite;
  logic flagOutD, flagOutDOe, chipSel, oscRunning, pullupFloat, ctrlStall;
  logic usbActivity = 1'b0, usbSuspend = 1'b0, ifaceClkExt = 1'b1, int30Clk = 1'b0;
  logic int48Clk = 1'b1, fifoReadIn = 1'b0, fifoWriteIn = 1'b0, chipSelIn = 1'b1;
  logic flagDValue = 1'b1;
  logic [63:0] reqPacket = 64'h8877665544332211;
  logic [7:0]  strobePolarity, c;
  logic [7:0]  cfgs [4] = '{8'hC9, 8'h89, 8'h18, 8'hF2};
  int errors = 0, compares = 0, stalls = 0, n, i;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (ctrlStall === 1'b1) stalls++;
  cmd_port_if bus();
  usb_iface_device i_usb_iface_device(.clk, .reset, .port(bus), .usbActivity, .usbSuspend,
    .ifaceClkExt, .int30Clk, .int48Clk, .fifoReadIn, .fifoWriteIn, .chipSelIn, .flagDValue,
    .reqPacket, .fifoClk, .ifaceClkOut, .ifaceClkOe, .fifoRead, .fifoWrite, .flagOutD,
    .flagOutDOe, .chipSel, .oscRunning, .pullupFloat, .ctrlStall, .strobePolarity);
  // Short waits keep the locked window from dominating run time.
  usb_iface_master #(.LEN_WAIT(20), .FLUSH_WAIT(20)) i_usb_iface_master(.clk, .reset,
    .port(bus), .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .irq);
  cmd_port_sva i_cmd_port_sva(.clk, .reset, .cmdValid(bus.cmdValid), .cmdWrite(bus.cmdWrite),
    .cmdAddr(bus.cmdAddr), .cmdWdata(bus.cmdWdata), .cmdReady(bus.cmdReady),
    .cmdRdata(bus.cmdRdata), .busActivityIrq(bus.busActivityIrq), .resumePin(bus.resumePin));
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask
  task tally_and_finish;
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task waitIdle;
    int k;
    k = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0);
      k++;
    end while (rv[0] !== 1'b0 && k < 40);
    if (rv[0] !== 1'b0) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, APB_CMD, {15'h0, w, a, d});
    waitIdle();
    if (!w) apb(1'b0, APB_RDATA, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    cmd(1'b0, OFS_IFACE_CFG, 8'h00);
    chk("cfg reset", RST_IFACE_CFG, rv[7:0]);
    chk("pull-up float", 1'b1, pullupFloat);
    chk("polarity reset", 8'h00, strobePolarity);
    cmd(1'b0, OFS_INT_MASK, 8'h00);
    chk("mask reset", RST_INT_MASK, rv[7:0]);
    for (i = 0; i < 4; i++) begin
      c = cfgs[i];
      cmd(1'b1, OFS_IFACE_CFG, c);
      cmd(1'b0, OFS_IFACE_CFG, 8'h00);
      chk("cfg", c, rv[7:0]);
      chk("fifo clock", (c[7] ? (c[6] ? int48Clk : int30Clk) : ifaceClkExt) ^ c[4],
          fifoClk);
      chk("clock drive", c[5], ifaceClkOe);
      chk("clock out", c[6] ? int48Clk : int30Clk, ifaceClkOut);
      chk("flag drive", c[1], flagOutDOe);
      chk("flag d", flagDValue, flagOutD);
      chk("chip select", !c[1], chipSel);
      chk("pull-up", c[0], pullupFloat);
      @(posedge clk);
      fifoReadIn  <= 1'b1;
      fifoWriteIn <= 1'b1;
      #1;
      chk("read strobe", c[3], fifoRead);
      chk("write strobe", c[3], fifoWrite);
      @(posedge clk);
      fifoReadIn  <= 1'b0;
      fifoWriteIn <= 1'b0;
      #1;
      chk("read enable", !c[3], fifoRead);
      chk("write enable", !c[3], fifoWrite);
    end
    cmd(1'b0, OFS_EP_BC, 8'h00);
    chk("count reset", 8'h00, rv[7:0]);
    cmd(1'b1, OFS_EP_BC, 8'hA5);
    cmd(1'b0, OFS_EP_BC, 8'h00);
    chk("count", 8'hA5, rv[7:0]);
    for (i = 0; i < REQ_PKT_BYTES; i++) begin
      cmd(1'b0, OFS_REQ_PKT, 8'h00);
      chk("request byte", reqPacket[8*i+:8], rv[7:0]);
    end
    cmd(1'b1, OFS_REQ_PKT, 8'h01);
    chk("stall pulses", 1, stalls);
    cmd(1'b1, OFS_PTR_LOW, XOFS_POLARITY[7:0]);
    cmd(1'b1, OFS_PTR_HIGH, XOFS_POLARITY[15:8]);
    cmd(1'b1, OFS_IND_DATA, 8'hFF);
    chk("polarity", POLARITY_MASK, strobePolarity);
    cmd(1'b0, OFS_IND_DATA, 8'h00);
    chk("polarity read", POLARITY_MASK, rv[7:0]);
    cmd(1'b1, OFS_PTR_LOW, XOFS_TOGGLE[7:0]);
    cmd(1'b1, OFS_PTR_HIGH, XOFS_TOGGLE[15:8]);
    cmd(1'b0, OFS_PTR_HIGH, 8'h00);
    chk("pointer high", XOFS_TOGGLE[15:8], rv[7:0]);
    cmd(1'b1, OFS_IND_DATA, 8'h5A);
    cmd(1'b0, OFS_IND_DATA, 8'h00);
    chk("toggle read", 8'h5A, rv[7:0]);
    chk("polarity kept", POLARITY_MASK, strobePolarity);
    cmd(1'b1, OFS_PKT_LEN_H, 8'h00);
    apb(1'b0, APB_STATUS, 32'h0);
    chk("length lock", 1'b1, rv[1]);
    repeat (30) @(posedge clk);
    apb(1'b0, APB_STATUS, 32'h0);
    chk("length unlock", 1'b0, rv[1]);
    cmd(1'b1, OFS_PKT_END, 8'h01);
    apb(1'b0, APB_STATUS, 32'h0);
    chk("flush lock", 1'b1, rv[1]);
    repeat (30) @(posedge clk);
    apb(1'b0, APB_STATUS, 32'h0);
    chk("flush unlock", 1'b0, rv[1]);
    apb(1'b0, APB_IRQ_ST, 32'h0);
    chk("done status", 1'b1, rv[1]);
    apb(1'b1, APB_IRQ_MK, 32'h2);
    @(posedge clk);
    chk("irq raised", 1'b1, irq);
    apb(1'b1, APB_IRQ_ST, 32'h2);
    @(posedge clk);
    chk("irq cleared", 1'b0, irq);
    // Pull-up is connected and no suspend seen yet, so sleep must be refused.
    apb(1'b1, APB_CMD, {15'h0, 1'b1, OFS_IFACE_CFG, 8'hF6});
    chk("sleep refused", 1'b1, e);
    usbSuspend <= 1'b1;
    apb(1'b1, APB_IRQ_MK, 32'h1);
    n = 0;
    do begin
      apb(1'b0, APB_IRQ_ST, 32'h0);
      n++;
    end while (rv[0] !== 1'b1 && n < 20);
    if (rv[0] !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
    chk("bus irq", 1'b1, irq);
    cmd(1'b1, OFS_IFACE_CFG, 8'hF6);
    chk("osc stopped", 1'b0, oscRunning);
    apb(1'b1, APB_CMD, {15'h0, 1'b0, OFS_EP_BC, 8'h00});
    apb(1'b0, APB_STATUS, 32'h0);
    chk("stalled busy", 1'b1, rv[0]);
    apb(1'b1, APB_CTRL, 32'h1);
    waitIdle();
    chk("osc running", 1'b1, oscRunning);
    apb(1'b1, APB_CTRL, 32'h0);
    apb(1'b0, APB_RDATA, 32'h0);
    chk("read after wake", 8'hA5, rv[7:0]);
    tally_and_finish();
  end
endmodule
`default_nettype wire
